// *** shared/ao_diag_params.svh ***
// Constants for the four-channel voltage output parameter and diagnostic record.
// Assumes byte-wide record accesses by record set or object index, one clock.
//
// What this block does
// - Short enable bits 0-3, one per channel
// - Function code FFh disables the channel
// - Code 10h: 27648 is 10 V, clamp 7EFFh
// - Code 20h: 16384 is 10 V, clamp 5000h
// - Negative codes drive 0 V
// - Channel errors light channel LED, record, no interrupt
// - Shorts reported only when enabled; parameter errors always
// - Summary bits 0,1,2,4 from module-level faults
// - Summary bit 3 channel error, bit 7 parameter
// - Module info: class 0101b, bit 4 channels present
// - Internal byte: bit 3 overflow, bit 4 comms
// - Channel kind reads 73h, analog output
// - Diagnostic bits per channel reads 08h
// - Channel count reads 04h
// - Group error byte bit n per channel
// - Detail bit 0 flags parameter error
// - Detail bit 3 flags short to ground
// - Timestamp captures microsecond counter on event
// - Microsecond counter starts at zero, ticks per us
// - Counter wraps to zero after maximum
// - Function codes reset to 10h
// - Short enable resets to 00h
`ifndef AO_DIAG_PARAMS_SVH
`define AO_DIAG_PARAMS_SVH

`define CLK_PERIOD_NS      8
`define MICROSECOND_NS     1000
`define US_CYCLES          (`MICROSECOND_NS / `CLK_PERIOD_NS)

`define RS_PARAM_BASE      8'h00
`define RS_DIAG            8'h01
`define RS_FUNC_CH0        8'h80
`define IX_DIAG_SHORT      16'h2F00
`define IX_DIAG            16'h2F01
`define IX_PARAM_RES       16'h3100
`define IX_SHORT_EN        16'h3101
`define IX_FUNC_CH0        16'h3102
`define PARAM_OFS_SHORT_EN 8'h01

`define DIAG_OFS_SUMMARY   8'h00
`define DIAG_OFS_MODINFO   8'h01
`define DIAG_OFS_INTERNAL  8'h03
`define DIAG_OFS_KIND      8'h04
`define DIAG_OFS_BITS      8'h05
`define DIAG_OFS_COUNT     8'h06
`define DIAG_OFS_GROUP     8'h07
`define DIAG_OFS_DETAIL0   8'h08
`define DIAG_OFS_STAMP     8'h10
`define DIAG_SHORT_LEN     8'h04
`define DIAG_LEN           8'h14

`define FN_NOM_RANGE       8'h10
`define FN_WIDE_RANGE      8'h20
`define FN_OFF             8'hFF
`define NOM_LIMIT          16'h7EFF
`define WIDE_LIMIT         16'h5000
`define WIDE_MULT          21'h00001B

`define RST_FUNC_CODE      8'h10
`define RST_SHORT_EN       8'h00
`define MODINFO_VALUE      8'h15
`define KIND_VALUE         8'h73
`define BITS_VALUE         8'h08
`define COUNT_VALUE        8'h04

`define SUM_FAIL_BIT       0
`define SUM_INT_BIT        1
`define SUM_EXT_BIT        2
`define SUM_CHAN_BIT       3
`define SUM_AUX_BIT        4
`define SUM_PARAM_BIT      7
`define INT_OVF_BIT        3
`define INT_COMM_BIT       4
`define DET_PARAM_BIT      0
`define DET_SHORT_BIT      3

`endif

// *** shared/ao_diag_pkg.sv ***
// Types shared by the record access port of the analog output diagnostic block.
// Assumes the params header supplies all numeric constants.
package ao_diag_pkg;

   typedef struct packed {
      logic        valid;
      logic        use_index;
      logic        write;
      logic [7:0]  record_set_selector;
      logic [15:0] object_index;
      logic [7:0]  byte_offset;
      logic [7:0]  wdata;
   } rec_req_t;

   typedef struct packed {
      logic       ack;
      logic       err;
      logic [7:0] rdata;
   } rec_rsp_t;

   typedef enum logic [1:0] {
      TARGET_NONE,
      TARGET_PARAM,
      TARGET_DIAG
   } target_t;

endpackage

// *** hw/analog_out_param_diag_record.sv ***
// Parameter and diagnostic record for a four-channel 0..10 V output module.
// Assumes the record requester runs on core_clk; fault inputs are asynchronous pins.
`timescale 1ns/10ps
`include "ao_diag_params.svh"

module analog_out_param_diag_record #(
   parameter int CHANNELS = 4
) (
   // Clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      reset,
   // Record access from the bus coupler
   input  wire ao_diag_pkg::rec_req_t     rec_req,
   output      ao_diag_pkg::rec_rsp_t     rec_rsp,
   // Output process image, same clock domain
   input  wire logic [CHANNELS-1:0][15:0] analog_value,
   // Fault pins, asynchronous
   input  wire logic                      module_failure,
   input  wire logic                      internal_error,
   input  wire logic                      external_error,
   input  wire logic                      aux_supply_missing,
   input  wire logic                      diag_buffer_overflow,
   input  wire logic                      internal_comm_error,
   input  wire logic [CHANNELS-1:0]       short_to_ground,
   // Converter side and indicators
   output      logic [CHANNELS-1:0][15:0] dac_level,
   output      logic [CHANNELS-1:0]       channel_active,
   output      logic [CHANNELS-1:0]       channel_error_led,
   output      logic                      group_error_led
);

   localparam int SYNC_W = 6 + CHANNELS;

   // Synchronised fault pins
   logic [SYNC_W-1:0]         sync_stage1;
   logic [SYNC_W-1:0]         sync_stage2;
   // Parameters
   logic [7:0]                short_detect_enable;
   logic [CHANNELS-1:0][7:0]  channel_function_code;
   // Diagnostic state
   logic [7:0]                diag_summary;
   logic [7:0]                diag_internal;
   logic [7:0]                channel_group_errors;
   logic [CHANNELS-1:0][7:0]  chan_error_detail;
   logic [31:0]               diag_timestamp_us;
   logic [31:0]               microsecond_count;
   logic [7:0]                us_prescale;
   // Next values
   logic [CHANNELS-1:0][7:0]  next_detail;
   logic [7:0]                next_summary;
   logic [7:0]                next_internal;
   logic [7:0]                next_group;
   logic [CHANNELS-1:0]       param_error;
   logic [CHANNELS-1:0]       short_error;
   logic [CHANNELS-1:0][15:0] next_dac;
   logic                      new_event;
   // Access decode
   ao_diag_pkg::target_t      req_target;
   logic [7:0]                param_slot;
   logic                      slot_ok;
   logic [7:0]                read_byte;

   logic sync_module_failure;
   logic sync_internal_error;
   logic sync_external_error;
   logic sync_aux_missing;
   logic sync_buffer_overflow;
   logic sync_comm_error;
   logic [CHANNELS-1:0] sync_short;

   // Two flops per pin; only sync_stage2 feeds logic
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sync_stage1 <= '0;
         sync_stage2 <= '0;
      end else begin
         sync_stage1 <= {short_to_ground, internal_comm_error, diag_buffer_overflow,
                         aux_supply_missing, external_error, internal_error, module_failure};
         sync_stage2 <= sync_stage1;
      end
   end

   assign sync_module_failure  = sync_stage2[0];
   assign sync_internal_error  = sync_stage2[1];
   assign sync_external_error  = sync_stage2[2];
   assign sync_aux_missing     = sync_stage2[3];
   assign sync_buffer_overflow = sync_stage2[4];
   assign sync_comm_error      = sync_stage2[5];
   assign sync_short           = sync_stage2[SYNC_W-1:6];

   // A code that is neither one of the supported ranges nor FFh is a parameter error
   function automatic logic code_supported(input logic [7:0] code);
      code_supported = (code == `FN_NOM_RANGE) || (code == `FN_WIDE_RANGE) || (code == `FN_OFF);
   endfunction

   // Map a record or index access onto the parameter or diagnostic record
   function automatic ao_diag_pkg::target_t decode_target(input ao_diag_pkg::rec_req_t r);
      logic [7:0] limit;
      limit = 8'h00;
      decode_target = ao_diag_pkg::TARGET_NONE;
      if (r.use_index) begin
         if (r.object_index == `IX_DIAG)
            limit = `DIAG_LEN;
         else if (r.object_index == `IX_DIAG_SHORT && !r.write)
            limit = `DIAG_SHORT_LEN;
         if (limit != 8'h00)
            decode_target = (r.byte_offset < limit) ? ao_diag_pkg::TARGET_DIAG : ao_diag_pkg::TARGET_NONE;
         else if (r.object_index >= `IX_PARAM_RES && r.object_index < `IX_FUNC_CH0 + 16'(CHANNELS)
                  && r.byte_offset == 8'h00)
            decode_target = ao_diag_pkg::TARGET_PARAM;
      end else begin
         if (r.record_set_selector == `RS_DIAG)
            limit = `DIAG_LEN;
         else if (r.record_set_selector == `RS_PARAM_BASE && !r.write)
            limit = `DIAG_SHORT_LEN;
         if (limit != 8'h00)
            decode_target = (r.byte_offset < limit) ? ao_diag_pkg::TARGET_DIAG : ao_diag_pkg::TARGET_NONE;
         else if (r.record_set_selector == `RS_PARAM_BASE && r.byte_offset <= `PARAM_OFS_SHORT_EN)
            decode_target = ao_diag_pkg::TARGET_PARAM;
         else if (r.record_set_selector >= `RS_FUNC_CH0
                  && r.record_set_selector < `RS_FUNC_CH0 + 8'(CHANNELS) && r.byte_offset == 8'h00)
            decode_target = ao_diag_pkg::TARGET_PARAM;
      end
   endfunction

   // Parameter slot: 0 reserved, 1 short enable, 2.. function codes
   function automatic logic [7:0] decode_slot(input ao_diag_pkg::rec_req_t r);
      if (r.use_index)
         decode_slot = 8'(r.object_index - `IX_PARAM_RES);
      else if (r.record_set_selector == `RS_PARAM_BASE)
         decode_slot = r.byte_offset;
      else
         decode_slot = 8'(r.record_set_selector - `RS_FUNC_CH0) + 8'h02;
   endfunction

   assign req_target = decode_target(rec_req);
   assign param_slot = decode_slot(rec_req);
   assign slot_ok    = req_target != ao_diag_pkg::TARGET_NONE;

   // Parameter writes
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         short_detect_enable <= `RST_SHORT_EN;
      end else if (rec_req.valid && rec_req.write && req_target == ao_diag_pkg::TARGET_PARAM
                   && param_slot == `PARAM_OFS_SHORT_EN) begin
         short_detect_enable <= {4'h0, rec_req.wdata[3:0]};
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
         logic [15:0] limited;
         logic [20:0] wide_product;

         always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
               channel_function_code[ch] <= `RST_FUNC_CODE;
            end else if (rec_req.valid && rec_req.write && req_target == ao_diag_pkg::TARGET_PARAM
                         && param_slot == 8'(ch + 2)) begin
               channel_function_code[ch] <= rec_req.wdata;
            end
         end

         // Error sources per channel
         assign param_error[ch] = !code_supported(channel_function_code[ch]);
         assign short_error[ch] = short_detect_enable[ch] && sync_short[ch]
                                  && channel_function_code[ch] != `FN_OFF;
         always_comb begin
            next_detail[ch]                 = 8'h00;
            next_detail[ch][`DET_PARAM_BIT] = param_error[ch];
            next_detail[ch][`DET_SHORT_BIT] = short_error[ch];
         end

         // Scaling into the 10h range so one converter scale serves both formats
         always_comb begin
            limited    = 16'h0000;
            wide_product = 21'h000000;
            next_dac[ch] = 16'h0000;
            if (analog_value[ch][15]) begin
               next_dac[ch] = 16'h0000;
            end else if (channel_function_code[ch] == `FN_NOM_RANGE) begin
               limited = (analog_value[ch] > `NOM_LIMIT) ? `NOM_LIMIT : analog_value[ch];
               next_dac[ch] = limited;
            end else if (channel_function_code[ch] == `FN_WIDE_RANGE) begin
               limited = (analog_value[ch] > `WIDE_LIMIT) ? `WIDE_LIMIT : analog_value[ch];
               wide_product = 21'(limited) * `WIDE_MULT;
               next_dac[ch] = wide_product[19:4];
            end
         end

         always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
               dac_level[ch]      <= 16'h0000;
               channel_active[ch] <= 1'b0;
            end else begin
               dac_level[ch]      <= next_dac[ch];
               channel_active[ch] <= code_supported(channel_function_code[ch])
                                     && channel_function_code[ch] != `FN_OFF;
            end
         end
      end
   endgenerate

   // Group bits and summary bits 3 and 7 are ORs of the detail bits computed in the same cycle
   always_comb begin
      next_group = 8'h00;
      for (int i = 0; i < CHANNELS; i++)
         next_group[i] = |next_detail[i];
      next_summary                 = 8'h00;
      next_summary[`SUM_FAIL_BIT]  = sync_module_failure;
      next_summary[`SUM_INT_BIT]   = sync_internal_error;
      next_summary[`SUM_EXT_BIT]   = sync_external_error;
      next_summary[`SUM_AUX_BIT]   = sync_aux_missing;
      next_summary[`SUM_CHAN_BIT]  = |next_group;
      next_summary[`SUM_PARAM_BIT] = |param_error;
      next_internal                = 8'h00;
      next_internal[`INT_OVF_BIT]  = sync_buffer_overflow;
      next_internal[`INT_COMM_BIT] = sync_comm_error;
   end

   // A newly raised bit anywhere in the record is an event worth stamping
   assign new_event = |(next_summary & ~diag_summary) || |(next_internal & ~diag_internal)
                      || |(next_detail & ~chan_error_detail);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         diag_summary         <= 8'h00;
         diag_internal        <= 8'h00;
         channel_group_errors <= 8'h00;
         chan_error_detail    <= '0;
      end else begin
         diag_summary         <= next_summary;
         diag_internal        <= next_internal;
         channel_group_errors <= next_group;
         chan_error_detail    <= next_detail;
      end
   end

   // Error indication goes to LEDs only; the block has no interrupt output
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         channel_error_led <= '0;
         group_error_led   <= 1'b0;
      end else begin
         channel_error_led <= next_group[CHANNELS-1:0];
         group_error_led   <= |next_summary;
      end
   end

   // Microsecond ticker
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         us_prescale       <= 8'h00;
         microsecond_count <= 32'h00000000;
      end else if (us_prescale == 8'(`US_CYCLES - 1)) begin
         us_prescale       <= 8'h00;
         microsecond_count <= microsecond_count + 32'h00000001;
      end else begin
         us_prescale <= us_prescale + 8'h01;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset)
         diag_timestamp_us <= 32'h00000000;
      else if (new_event)
         diag_timestamp_us <= microsecond_count;
   end

   // Read mux over the record bytes
   always_comb begin
      read_byte = 8'h00;
      if (req_target == ao_diag_pkg::TARGET_PARAM) begin
         if (param_slot == `PARAM_OFS_SHORT_EN)
            read_byte = short_detect_enable;
         else if (param_slot >= 8'h02)
            read_byte = channel_function_code[2'(param_slot - 8'h02)];
      end else if (req_target == ao_diag_pkg::TARGET_DIAG) begin
         case (rec_req.byte_offset)
            `DIAG_OFS_SUMMARY:  read_byte = diag_summary;
            `DIAG_OFS_MODINFO:  read_byte = `MODINFO_VALUE;
            `DIAG_OFS_INTERNAL: read_byte = diag_internal;
            `DIAG_OFS_KIND:     read_byte = `KIND_VALUE;
            `DIAG_OFS_BITS:     read_byte = `BITS_VALUE;
            `DIAG_OFS_COUNT:    read_byte = `COUNT_VALUE;
            `DIAG_OFS_GROUP:    read_byte = channel_group_errors;
            default: begin
               if (rec_req.byte_offset >= `DIAG_OFS_STAMP)
                  read_byte = diag_timestamp_us[8*rec_req.byte_offset[1:0] +: 8];
               else if (rec_req.byte_offset >= `DIAG_OFS_DETAIL0
                        && rec_req.byte_offset < `DIAG_OFS_DETAIL0 + 8'(CHANNELS))
                  read_byte = chan_error_detail[rec_req.byte_offset[1:0]];
               else
                  read_byte = 8'h00;
            end
         endcase
      end
   end

   // Answer one cycle after the request; diagnostic writes are refused
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rec_rsp <= '0;
      end else begin
         rec_rsp.ack   <= rec_req.valid;
         rec_rsp.err   <= rec_req.valid && (!slot_ok
                          || (rec_req.write && req_target == ao_diag_pkg::TARGET_DIAG));
         rec_rsp.rdata <= (rec_req.valid && !rec_req.write) ? read_byte : 8'h00;
      end
   end

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence s_short_enable_write;
      rec_req.valid && rec_req.write && !rec_req.use_index
      && rec_req.record_set_selector == `RS_PARAM_BASE && rec_req.byte_offset == `PARAM_OFS_SHORT_EN;
   endsequence

   AST_SHORT_EN_WRITE: assert property (
      s_short_enable_write |=> short_detect_enable == {4'h0, $past(rec_req.wdata[3:0])})
      else $error("short enable did not take written low nibble");

   AST_OFF_CHANNEL: assert property (
      channel_function_code[0] == `FN_OFF |=> !channel_active[0] && dac_level[0] == 16'h0000)
      else $error("disabled channel still active");

   AST_NOM_CLAMP: assert property (
      channel_function_code[0] == `FN_NOM_RANGE && !analog_value[0][15] && analog_value[0] > `NOM_LIMIT
      |=> dac_level[0] == `NOM_LIMIT)
      else $error("10h overrange not clamped to 7EFFh");

   AST_WIDE_NOMINAL: assert property (
      channel_function_code[0] == `FN_WIDE_RANGE && analog_value[0] == 16'h4000 |=> dac_level[0] == 16'h6C00)
      else $error("20h nominal 4000h not scaled to 10 V level");

   AST_NEG_ZERO: assert property (
      analog_value[1][15] |=> dac_level[1] == 16'h0000)
      else $error("negative code drove nonzero output");

   AST_SHORT_GATED: assert property (
      !short_detect_enable[2] |=> !chan_error_detail[2][`DET_SHORT_BIT])
      else $error("short reported on channel without detection");

   AST_PARAM_ALWAYS: assert property (
      !code_supported(channel_function_code[3]) |=> diag_summary[`SUM_PARAM_BIT] && chan_error_detail[3][0])
      else $error("parameter error not reported");

   AST_GROUP_OR: assert property (
      channel_group_errors[3:0] == {|chan_error_detail[3], |chan_error_detail[2],
                                   |chan_error_detail[1], |chan_error_detail[0]}
      && diag_summary[`SUM_CHAN_BIT] == |channel_group_errors)
      else $error("group or summary bits disagree with detail bytes");

   AST_LED_FOLLOWS: assert property (
      channel_error_led == channel_group_errors[CHANNELS-1:0])
      else $error("channel LED does not match channel error");

   AST_US_TICK: assert property (
      $changed(microsecond_count) |-> ##1 $stable(microsecond_count) [*8])
      else $error("microsecond counter ticks too fast");

   AST_STAMP: assert property (
      new_event |=> diag_timestamp_us == $past(microsecond_count))
      else $error("timestamp not captured on event");

   AST_ANSWER: assert property (
      rec_req.valid && !rec_req.write && rec_req.use_index && rec_req.object_index == `IX_DIAG
      && rec_req.byte_offset == `DIAG_OFS_KIND |=> rec_rsp.ack && !rec_rsp.err && rec_rsp.rdata == 8'h73)
      else $error("channel kind not read through full record index");

endmodule

// *** test/coupler_model.sv ***
// Bus coupler stand-in that issues byte-wide record accesses.
// Assumes the record port answers one cycle after the taking edge.
`timescale 1ns/10ps
module coupler_model (
   // Clock
   input  wire logic                  core_clk,
   // Record port
   output      ao_diag_pkg::rec_req_t rec_req,
   input  wire ao_diag_pkg::rec_rsp_t rec_rsp
);
   initial rec_req = '0;
   // Request held through the taking edge; a missing ack shows as an unknown error flag
   task automatic xfer(input logic ix, input logic wr, input logic [15:0] adr, input logic [7:0] ofs,
                       input logic [7:0] wd, input int gap, output logic er, output logic [7:0] rd);
      repeat (gap) @(posedge core_clk);
      rec_req <= '{1'b1, ix, wr, adr[7:0], adr, ofs, wd};
      @(posedge core_clk);
      rec_req.valid <= 1'b0;
      @(posedge core_clk);
      er = rec_rsp.ack ? rec_rsp.err : 1'bx;
      rd = rec_rsp.rdata;
   endtask
endmodule

// *** test/tb.sv ***
// Self-checking bench for the analog output parameter and diagnostic record.
// Assumes coupler_model drives the record port; fault pins are driven here.
`timescale 1ns/10ps
module tb;
   typedef struct packed {
      logic        ix;
      logic        wr;
      logic [15:0] adr;
      logic [7:0]  ofs;
      logic        er;
      logic [7:0]  rd;
   } row_t;
   logic                  core_clk;
   logic                  reset;
   ao_diag_pkg::rec_req_t rec_req;
   ao_diag_pkg::rec_rsp_t rec_rsp;
   logic [3:0][15:0]      analog_value;
   logic [5:0]            mod_pins;
   logic [3:0]            short_to_ground;
   logic [3:0][15:0]      dac_level;
   logic [3:0]            channel_active;
   logic [3:0]            channel_error_led;
   logic                  group_error_led;
   logic                  er;
   logic [7:0]            rd;
   logic [31:0]           stamp;
   int error_cnt = 0, checked = 0, cyc = 0, ev_cyc, rel_cyc, exp_us;
   row_t rows [9] = '{'{1'b0, 1'b0, 16'h0001, 8'h01, 1'b0, 8'h15}, '{1'b0, 1'b0, 16'h0001, 8'h02, 1'b0, 8'h00},
      '{1'b1, 1'b0, 16'h2F01, 8'h04, 1'b0, 8'h73}, '{1'b1, 1'b0, 16'h2F01, 8'h05, 1'b0, 8'h08},
      '{1'b0, 1'b0, 16'h0001, 8'h06, 1'b0, 8'h04}, '{1'b0, 1'b0, 16'h0001, 8'h0C, 1'b0, 8'h00},
      '{1'b0, 1'b0, 16'h0000, 8'h01, 1'b0, 8'h15}, '{1'b1, 1'b0, 16'h2F00, 8'h04, 1'b1, 8'h00},
      '{1'b1, 1'b1, 16'h2F01, 8'h00, 1'b1, 8'h00}};
   logic [3:0][15:0] vin [2] = '{{16'hFFFF, 16'h1234, 16'h4000, 16'h7F00}, {16'h8000, 16'h1234, 16'h5001, 16'h6C00}};
   logic [3:0][15:0] vout [2] = '{{16'h0000, 16'h0000, 16'h6C00, 16'h7EFF}, {16'h0000, 16'h0000, 16'h8700, 16'h6C00}};
   logic [7:0] diag_exp [16] = '{8'h9F, 8'h15, 8'h00, 8'h18, 8'h73, 8'h08, 8'h04, 8'h0A,
                                 8'h00, 8'h08, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

   analog_out_param_diag_record dut_u (.core_clk(core_clk), .reset(reset), .rec_req(rec_req), .rec_rsp(rec_rsp),
      .analog_value(analog_value), .module_failure(mod_pins[0]), .internal_error(mod_pins[1]),
      .external_error(mod_pins[2]), .aux_supply_missing(mod_pins[3]), .diag_buffer_overflow(mod_pins[4]),
      .internal_comm_error(mod_pins[5]), .short_to_ground(short_to_ground), .dac_level(dac_level),
      .channel_active(channel_active), .channel_error_led(channel_error_led), .group_error_led(group_error_led));
   coupler_model cm_u (.core_clk(core_clk), .rec_req(rec_req), .rec_rsp(rec_rsp));

   task automatic chk_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic chk_level(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // The whole run is about 1150 cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         test_done();
      end
   end

   initial begin
      reset = 1'b1;
      analog_value = '0;
      mod_pins = '0;
      short_to_ground = '0;
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      rel_cyc = cyc;
      @(posedge core_clk);
      foreach (rows[i]) begin
         cm_u.xfer(rows[i].ix, rows[i].wr, rows[i].adr, rows[i].ofs, 8'h00, i % 2, er, rd);
         chk_byte("rsp_err", {7'h00, rows[i].er}, {7'h00, er});
         if (rows[i].er === 1'b0) chk_byte("rsp_data", rows[i].rd, rd);
      end
      $display("test record_map done");
      cm_u.xfer(1'b1, 1'b1, 16'h3103, 8'h00, 8'h20, 0, er, rd);
      cm_u.xfer(1'b0, 1'b1, 16'h0082, 8'h00, 8'hFF, 0, er, rd);
      cm_u.xfer(1'b0, 1'b0, 16'h0081, 8'h00, 8'h00, 0, er, rd);
      chk_byte("function_code", 8'h20, rd);
      for (int s = 0; s < 2; s++) begin
         @(posedge core_clk);
         analog_value <= vin[s];
         repeat (4) @(posedge core_clk);
         for (int c = 0; c < 4; c++) chk_level("dac_level", vout[s][c], dac_level[c]);
      end
      chk_byte("channel_active", 8'h0B, {4'h0, channel_active});
      $display("test scaling done");
      // Ch0 shorts too but stays silent because its enable bit is clear
      cm_u.xfer(1'b0, 1'b1, 16'h0000, 8'h01, 8'hF2, 0, er, rd);
      cm_u.xfer(1'b1, 1'b0, 16'h3101, 8'h00, 8'h00, 1, er, rd);
      chk_byte("short_enable", 8'h02, rd);
      cm_u.xfer(1'b1, 1'b1, 16'h3105, 8'h00, 8'h05, 0, er, rd);
      repeat (1000) @(posedge core_clk);
      mod_pins <= 6'h3F;
      short_to_ground <= 4'h3;
      ev_cyc = cyc;
      repeat (6) @(posedge core_clk);
      chk_byte("error_leds", 8'h1A, {3'h0, group_error_led, channel_error_led});
      for (int k = 0; k < 20; k++) begin
         cm_u.xfer(1'b1, 1'b0, 16'h2F01, k[7:0], 8'h00, 0, er, rd);
         if (k < 16) chk_byte("diag_byte", diag_exp[k], rd);
         else stamp[8*(k-16) +: 8] = rd;
      end
      exp_us = (ev_cyc - rel_cyc) / 125;
      chk_byte("stamp_window", 8'h01, {7'h00, stamp >= exp_us - 1 && stamp <= exp_us + 1});
      $display("test diagnostics done");
      reset <= 1'b1;
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      #1;
      chk_byte("channel_active", 8'h0F, {4'h0, channel_active});
      cm_u.xfer(1'b1, 1'b0, 16'h3101, 8'h00, 8'h00, 1, er, rd);
      chk_byte("short_enable", 8'h00, rd);
      for (int c = 0; c < 4; c++) begin
         cm_u.xfer(1'b1, 1'b0, 16'h3102 + c[15:0], 8'h00, 8'h00, 0, er, rd);
         chk_byte("function_code", 8'h10, rd);
      end
      $display("test reset done");
      test_done();
   end
endmodule
